/* File: common/lseu_pkg.sv */
// Constants, types and helpers shared by the load and store execution unit
`default_nettype none

package lseu_pkg;

  // General register and storage address widths
  localparam int REG_W = 22;
  localparam int ADDR_W = 22;

  // Register map byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_AEXT = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_IAR = 8'h0c;
  localparam logic [7:0] OFF_EXT44 = 8'h10;
  localparam logic [7:0] OFF_EXT45 = 8'h14;
  localparam logic [7:0] OFF_EXT46 = 8'h18;
  localparam logic [2:0] OFF_GPR_HI = 3'h1;

  // Status register field positions
  localparam int ST_BUSY = 0;
  localparam int ST_CARRY = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_INV = 3;
  localparam int ST_BR = 4;

  // Reset values
  localparam logic [REG_W-1:0] RST_REG = 22'h000000;
  localparam logic [15:0] RST_HW = 16'h0000;

  // Opcode fields of the first instruction halfword
  localparam logic [7:0] OPC_ICT_LO = 8'h10;
  localparam logic [7:0] OPC_BYTE_SHIFT_COPY_LO = 8'h78;
  localparam logic [4:0] OPC_LA_HI = 5'h17;
  localparam logic [3:0] OPC_LA_MID = 4'h0;

  // Storage access sizes on the memory port
  localparam logic [1:0] MSZ_BYTE = 2'h0;
  localparam logic [1:0] MSZ_HALF = 2'h1;
  localparam logic [1:0] MSZ_WORD = 2'h2;

  // Only the low 22 bits of a stored fullword are altered
  localparam logic [31:0] ST_MASK = 32'h003fffff;

  // Word-size code accepted on the bus
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    OP_L, OP_LH, OP_IC, OP_ICT, OP_LA, OP_ST, OP_BYTE_SHIFT_COPY, OP_BAD
  } lseu_op_t;

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_MEM, S_WB} lseu_state_t;

  // Byte 0 sits at bits 15..8, byte 1 at bits 7..0
  function automatic logic [7:0] sel_byte(input logic [REG_W-1:0] r, input logic n);
    sel_byte = n ? r[7:0] : r[15:8];
  endfunction

  function automatic logic [REG_W-1:0] put_byte(input logic [REG_W-1:0] r, input logic n,
                                                input logic [7:0] b);
    put_byte = n ? {r[21:8], b} : {r[21:16], b, r[7:0]};
  endfunction

endpackage

`default_nettype wire

/* File: core/lseu_core.sv */
// Load, insert, load-address and fullword store execution unit with AHB-Lite registers
//
// Added by the designer: the AHB-Lite slave port and the address map.
`default_nettype none

module lseu_core
  import lseu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  output logic [31:0] mem_wmask,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic busy,
  output logic carry_latch,
  output logic zero_latch,
  output logic branch_pulse,
  output logic [REG_W-1:0] branch_addr,
  output logic invalid_op_check
);

  // State and storage
  lseu_state_t state_reg, state_next;
  logic [REG_W-1:0] gpr_reg [8];
  logic [REG_W-1:0] ext44_reg, ext45_reg, ext46_reg;
  logic [15:0] ir_reg, aext_reg;
  logic [31:0] rd_reg, hrdata_reg;
  logic carry_reg, zero_reg, inv_reg, br_reg;
  logic br_pulse_reg, inv_pulse_reg;
  logic dp_we_reg;
  logic [7:0] dp_off_reg;
  logic mem_req_reg, mem_we_reg;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [1:0] mem_size_reg;
  logic [31:0] mem_wdata_reg, mem_wmask_reg;

  // Bus address phase and register decode
  wire logic ap_take = hsel & hready & htrans[1];
  wire logic ap_hit = (haddr[31:8] == 24'h000000) & (hsize == HSIZE_WORD);
  wire logic [7:0] ap_off = haddr[7:0];
  wire logic ap_gpr = ap_off[7:5] == OFF_GPR_HI && ap_off[1:0] == 2'h0;
  wire logic [2:0] ap_gidx = ap_off[4:2];
  wire logic [31:0] stat_word = {27'h0, br_reg, inv_reg, zero_reg, carry_reg, busy};
  wire logic [31:0] rd_mux =
    !ap_hit ? 32'h00000000 :
    (ap_off == OFF_CMD) ? {16'h0000, ir_reg} :
    (ap_off == OFF_AEXT) ? {16'h0000, aext_reg} :
    (ap_off == OFF_STAT) ? stat_word :
    (ap_off == OFF_IAR) ? {10'h000, gpr_reg[0]} :
    (ap_off == OFF_EXT44) ? {10'h000, ext44_reg} :
    (ap_off == OFF_EXT45) ? {10'h000, ext45_reg} :
    (ap_off == OFF_EXT46) ? {10'h000, ext46_reg} :
    ap_gpr ? {10'h000, gpr_reg[ap_gidx]} : 32'h00000000;

  // Data phase write strobes; instruction, AEXT, IAR and general register writes only take effect while idle
  wire logic idle = state_reg == S_IDLE;
  wire logic wr_cmd = dp_we_reg & (dp_off_reg == OFF_CMD);
  wire logic wr_aext = dp_we_reg & (dp_off_reg == OFF_AEXT) & idle;
  wire logic wr_stat = dp_we_reg & (dp_off_reg == OFF_STAT);
  wire logic wr_iar = dp_we_reg & (dp_off_reg == OFF_IAR) & idle;
  wire logic wr_e44 = dp_we_reg & (dp_off_reg == OFF_EXT44);
  wire logic wr_e45 = dp_we_reg & (dp_off_reg == OFF_EXT45);
  wire logic wr_e46 = dp_we_reg & (dp_off_reg == OFF_EXT46);
  wire logic wr_gpr = dp_we_reg & (dp_off_reg[7:5] == OFF_GPR_HI) &
                      (dp_off_reg[1:0] == 2'h0) & idle;
  wire logic start = wr_cmd & idle;

  // Instruction fields
  wire logic [2:0] base_f = ir_reg[14:12];
  wire logic [2:0] r_f = ir_reg[10:8];
  wire logic nsel = ir_reg[8];
  wire logic [2:0] odd_r = {ir_reg[10:9], 1'b1};
  wire logic [2:0] src_r = {ir_reg[14:13], 1'b1};
  wire logic src_n = ir_reg[12];
  wire logic [7:0] lo = ir_reg[7:0];

  // Opcode decode; anything outside this unit's set is flagged invalid
  wire logic is_la = ir_reg[15:11] == OPC_LA_HI && ir_reg[7:4] == OPC_LA_MID;
  wire logic rs_form = ~ir_reg[15];
  wire lseu_op_t op =
    is_la ? OP_LA :
    !rs_form ? OP_BAD :
    (!ir_reg[11] && lo == OPC_BYTE_SHIFT_COPY_LO) ? OP_BYTE_SHIFT_COPY :
    (!ir_reg[11] && lo == OPC_ICT_LO) ? OP_ICT :
    (ir_reg[11] && !ir_reg[7]) ? OP_IC :
    (!ir_reg[11] && !ir_reg[7] && ir_reg[0]) ? OP_LH :
    (!ir_reg[11] && !ir_reg[7] && ir_reg[1:0] == 2'h2) ? OP_L :
    (!ir_reg[11] && ir_reg[7] && ir_reg[1:0] == 2'h2) ? OP_ST : OP_BAD;

  wire logic [ADDR_W-1:0] disp_l = {15'h0000, ir_reg[6:2], 2'h0};
  wire logic [ADDR_W-1:0] disp_lh = {15'h0000, ir_reg[6:1], 1'b0};
  wire logic [ADDR_W-1:0] disp_ic = {15'h0000, ir_reg[6:0]};
  wire logic [ADDR_W-1:0] disp =
    (op == OP_LH) ? disp_lh :
    (op == OP_IC) ? disp_ic :
    (op == OP_ICT) ? RST_REG : disp_l;

  // Base 0 selects the external base register of the access size
  // fullword base external
  wire logic [REG_W-1:0] ext_base =
    (op == OP_LH) ? ext45_reg :
    (op == OP_IC) ? ext44_reg : ext46_reg;
  wire logic [REG_W-1:0] base_val = (base_f == 3'h0) ? ext_base : gpr_reg[base_f];

  // unsigned add, wraps at 22 bits
  wire logic [ADDR_W-1:0] ea = base_val + disp;
  wire logic byte_acc = (op == OP_IC) | (op == OP_ICT);
  wire logic [ADDR_W-1:0] ea_acc = byte_acc ? ea : {ea[ADDR_W-1:1], 1'b0};

  // Memory size and store data; register 0 as source stores zeros
  wire logic [1:0] acc_size =
    byte_acc ? MSZ_BYTE : (op == OP_LH) ? MSZ_HALF : MSZ_WORD;
  wire logic [31:0] st_data = (r_f == 3'h0) ? 32'h00000000 : {10'h000, gpr_reg[r_f]};
  wire logic is_mem = (op == OP_L) | (op == OP_LH) | (op == OP_IC) | (op == OP_ST) |
                      ((op == OP_ICT) & (base_f != 3'h0));

  // Result values
  wire logic exec_now = state_reg == S_EXEC;
  wire logic wb_now = state_reg == S_WB;
  // immediate fills X, 0 and 1
  wire logic [REG_W-1:0] la_val = {2'h0, ir_reg[3:0], aext_reg};
  // low 22 bits of the fullword
  wire logic [REG_W-1:0] l_val = rd_reg[REG_W-1:0];
  wire logic [REG_W-1:0] lh_val = {6'h00, rd_reg[15:0]};
  wire logic [REG_W-1:0] ld_val =
    (op == OP_LA) ? la_val : (op == OP_L) ? l_val : lh_val;

  // Shift-copy: selected source byte moved right one place
  wire logic [7:0] src_byte = sel_byte(gpr_reg[src_r], src_n);
  wire logic [7:0] byte_shift_copy_res = {1'b0, src_byte[7:1]};
  wire logic [7:0] byte_val = (op == OP_BYTE_SHIFT_COPY) ? byte_shift_copy_res : rd_reg[7:0];

  wire logic [REG_W-1:0] base_inc = gpr_reg[base_f] + 22'h000001;
  wire logic [REG_W-1:0] byte_host =
    ((op == OP_ICT) && (odd_r == base_f)) ? base_inc : gpr_reg[odd_r];

  // Write-back fire conditions
  wire logic wide_fire = (wb_now & ((op == OP_L) | (op == OP_LH))) |
                         (exec_now & (op == OP_LA));
  wire logic byte_fire = (wb_now & byte_acc) | (exec_now & (op == OP_BYTE_SHIFT_COPY));
  wire logic br_take = wide_fire & (r_f == 3'h0);
  wire logic tgt_we = (wide_fire & (r_f != 3'h0)) | byte_fire;
  wire logic [2:0] tgt_idx = byte_fire ? odd_r : r_f;
  wire logic [REG_W-1:0] tgt_data = byte_fire ? put_byte(byte_host, nsel, byte_val) : ld_val;
  wire logic base_we = wb_now & (op == OP_ICT);

  // Latch update; branches, immediate loads and autoincrement leave them alone
  wire logic lat_we = (wide_fire & (r_f != 3'h0) & (op != OP_LA)) |
                      (byte_fire & (op != OP_ICT));
  wire logic c_next =
    (op == OP_BYTE_SHIFT_COPY) ? src_byte[0] :
    byte_acc ? ~^byte_val : (ld_val != RST_REG);
  wire logic z_next = byte_fire ? (byte_val == 8'h00) : (ld_val == RST_REG);

  wire logic inv_set = exec_now & ((op == OP_BAD) | ((op == OP_ICT) & (base_f == 3'h0)));
  // Sticky flags: a hardware set in the clearing cycle survives
  wire logic inv_next = inv_set | (inv_reg & ~(wr_stat & hwdata[ST_INV]));
  wire logic br_next = br_take | (br_reg & ~(wr_stat & hwdata[ST_BR]));

  // Sequencer: one instruction at a time, memory wait is unbounded
  always_comb begin
    case (state_reg)
      S_IDLE: state_next = start ? S_EXEC : S_IDLE;
      S_EXEC: state_next = is_mem ? S_MEM : S_IDLE;
      S_MEM: state_next = mem_ack ? S_WB : S_MEM;
      S_WB: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bus slave: zero wait states, read data captured in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_we_reg <= 1'b0;
      dp_off_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else begin
      dp_we_reg <= ap_take & hwrite & ap_hit;
      dp_off_reg <= ap_off;
      if (ap_take && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // Software-written control words and external base registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_reg <= RST_HW;
      aext_reg <= RST_HW;
      ext44_reg <= RST_REG;
      ext45_reg <= RST_REG;
      ext46_reg <= RST_REG;
    end else begin
      if (start) begin
        ir_reg <= hwdata[15:0];
      end
      if (wr_aext) begin
        aext_reg <= hwdata[15:0];
      end
      if (wr_e44) begin
        ext44_reg <= hwdata[REG_W-1:0];
      end
      if (wr_e45) begin
        ext45_reg <= hwdata[REG_W-1:0];
      end
      if (wr_e46) begin
        ext46_reg <= hwdata[REG_W-1:0];
      end
    end
  end

  // General registers; target write follows base write so it wins on a clash
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 8; i++) begin
        gpr_reg[i] <= RST_REG;
      end
    end else begin
      if (wr_gpr) begin
        gpr_reg[dp_off_reg[4:2]] <= hwdata[REG_W-1:0];
      end
      if (wr_iar) begin
        gpr_reg[0] <= hwdata[REG_W-1:0];
      end
      if (base_we) begin
        gpr_reg[base_f] <= base_inc;
      end
      if (tgt_we) begin
        gpr_reg[tgt_idx] <= tgt_data;
      end
      if (br_take) begin
        gpr_reg[0] <= ld_val;
      end
    end
  end

  // Condition latches and event flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carry_reg <= 1'b0;
      zero_reg <= 1'b0;
      inv_reg <= 1'b0;
      br_reg <= 1'b0;
      br_pulse_reg <= 1'b0;
      inv_pulse_reg <= 1'b0;
    end else begin
      if (lat_we) begin
        carry_reg <= c_next;
        zero_reg <= z_next;
      end
      inv_reg <= inv_next;
      br_reg <= br_next;
      br_pulse_reg <= br_take;
      inv_pulse_reg <= inv_set;
    end
  end

  // Storage request, held until the far side acknowledges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= RST_REG;
      mem_size_reg <= MSZ_BYTE;
      mem_wdata_reg <= 32'h00000000;
      mem_wmask_reg <= 32'h00000000;
      rd_reg <= 32'h00000000;
    end else begin
      if (exec_now && is_mem) begin
        mem_req_reg <= 1'b1;
        mem_we_reg <= op == OP_ST;
        // fetch address is the base itself
        mem_addr_reg <= (op == OP_ICT) ? gpr_reg[base_f] : ea_acc;
        mem_size_reg <= acc_size;
        mem_wdata_reg <= st_data;
        mem_wmask_reg <= (op == OP_ST) ? ST_MASK : 32'h00000000;
      end else if (state_reg == S_MEM && mem_ack) begin
        mem_req_reg <= 1'b0;
        rd_reg <= mem_rdata;
      end
    end
  end

  // Output drive
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_size = mem_size_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_wmask = mem_wmask_reg;
  assign busy = ~idle;
  assign carry_latch = carry_reg;
  assign zero_latch = zero_reg;
  assign branch_pulse = br_pulse_reg;
  assign branch_addr = gpr_reg[0];
  assign invalid_op_check = inv_pulse_reg;

endmodule

`default_nettype wire

/* File: tb/lseu_core_chk.sv */
// Assertions on the execution unit's storage port and branch events
`default_nettype none
module lseu_core_chk
  import lseu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_wmask,
  input wire logic mem_ack,
  input wire logic busy,
  input wire logic carry_latch,
  input wire logic zero_latch,
  input wire logic branch_pulse,
  input wire logic invalid_op_check
);
  // One clock domain throughout
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Request held steady until acknowledged, then dropped while still busy
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request moved before ack");
  ack_end_a: assert property (mem_req && mem_ack |=> !mem_req && busy)
    else $error("request after ack");
  // Storage side effects of each access kind
  even_addr_a: assert property (mem_req && mem_size != MSZ_BYTE |-> !mem_addr[0])
    else $error("odd halfword address");
  store_mask_a: assert property (mem_req && mem_we |-> mem_wmask == ST_MASK)
    else $error("store mask wrong");
  store_data_a: assert property (mem_req && mem_we |-> mem_wdata[31:22] == 10'h000)
    else $error("store data too wide");
  read_mask_a: assert property (mem_req && !mem_we |-> mem_wmask == 32'h0)
    else $error("read alters storage");
  // Branch and check events are single pulses; a branch leaves the latches alone
  br_pulse_a: assert property (branch_pulse |=> !branch_pulse)
    else $error("branch pulse too long");
  br_keep_a: assert property (branch_pulse |-> carry_latch == $past(carry_latch, 3)
    && zero_latch == $past(zero_latch, 3))
    else $error("latches moved on branch");
  inv_pulse_a: assert property (invalid_op_check |=> !invalid_op_check)
    else $error("check pulse too long");

  cover property (mem_req && mem_we && mem_ack);
  cover property (mem_req && !mem_ack ##1 mem_ack);
  cover property (branch_pulse);
  cover property (invalid_op_check);
endmodule

bind lseu_core lseu_core_chk chk (.hclk, .hresetn, .mem_req, .mem_we, .mem_addr, .mem_size,
  .mem_wdata, .mem_wmask, .mem_ack, .busy, .carry_latch, .zero_latch, .branch_pulse,
  .invalid_op_check);
`default_nettype wire

/* File: tb/lseu_mem_model.sv */
// Behavioural byte storage answering the unit's request port
`default_nettype none
module lseu_mem_model
  import lseu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_wmask,
  input wire logic [3:0] lat,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [256];
  logic [7:0] a;
  logic [3:0] cnt;
  logic tog;
  logic [31:0] word;

  // Big-endian view; latency set by the bench gives prompt or slow answers
  assign a = mem_addr[7:0];
  assign word = {m[a], m[a + 8'h1], m[a + 8'h2], m[a + 8'h3]};
  assign mem_ack = mem_req && cnt == lat;

  // Off-ack data toggles so stale values cannot pass by luck
  always_comb begin
    if (!mem_ack) mem_rdata = 32'hc3c3c3c3 ^ {32{tog}};
    else if (mem_size == MSZ_WORD) mem_rdata = word;
    else if (mem_size == MSZ_HALF) mem_rdata = {16'h0000, word[31:16]};
    else mem_rdata = {24'h000000, word[31:24]};
  end

  initial begin
    for (int i = 0; i < 256; i++) m[i] = 8'(i) ^ 8'ha5;
  end

  // Wait counter and masked store
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
      cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
      if (mem_ack && mem_we)
        {m[a], m[a + 8'h1], m[a + 8'h2], m[a + 8'h3]} <=
          (word & ~mem_wmask) | (mem_wdata & mem_wmask);
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_lseu_core.sv */
// Self-checking bench for the load and store execution unit
`default_nettype none
module tb_lseu_core
  import lseu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy, mem_req, mem_we, mem_ack;
  logic carry_latch, zero_latch, branch_pulse, invalid_op_check;
  logic [1:0] htrans, mem_size;
  logic [2:0] hsize;
  logic [3:0] lat;
  logic [21:0] mem_addr, branch_addr;
  logic [31:0] haddr, hwdata, hrdata, mem_wdata, mem_wmask, mem_rdata, rd;
  int failures, compares;

  lseu_core dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mem_req, .mem_we, .mem_addr,
    .mem_size, .mem_wdata, .mem_wmask, .mem_rdata, .mem_ack, .busy, .carry_latch,
    .zero_latch, .branch_pulse, .branch_addr, .invalid_op_check);
  lseu_mem_model mem (.hclk, .hresetn, .mem_req, .mem_we, .mem_addr, .mem_size,
    .mem_wdata, .mem_wmask, .lat, .mem_rdata, .mem_ack);

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Storage image the partner starts from
  function automatic logic [7:0] pb(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Single transfer: address phase held until ready, data taken at the closing edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Run one instruction, then check a register and the two latches
  task automatic op(input logic [15:0] ins, input logic [7:0] ga, input logic [31:0] exp,
    input logic [1:0] zc);
    bus(1'b1, OFF_CMD, {16'h0000, ins});
    @(negedge hclk);
    while (busy !== 1'b0) @(negedge hclk);
    @(posedge hclk);
    bus(1'b0, ga, 32'h0);
    chk(rd, exp);
    bus(1'b0, OFF_STAT, 32'h0);
    chk({30'h0, rd[ST_ZERO], rd[ST_CARRY]}, {30'h0, zc});
  endtask

  // Sticky status bit seen, then cleared by writing one
  task automatic sticky(input logic [31:0] m);
    bus(1'b0, OFF_STAT, 32'h0);
    chk(rd & 32'h18, m);
    bus(1'b1, OFF_STAT, m);
    bus(1'b0, OFF_STAT, 32'h0);
    chk(rd & 32'h18, 32'h0);
  endtask

  // Fullword load from odd base at top displacement, zero store, load via external base
  task automatic t_load;
    bus(1'b1, 8'h1c, 32'h12345678);
    bus(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    lat <= 4'h3;
    bus(1'b1, 8'h24, 32'h21);
    op(16'h137e, 8'h2c, {8'h0, pb(8'h9d), pb(8'h9e), pb(8'h9f)} & 32'h3fffff, 2'b01);
    bus(1'b1, OFF_EXT46, 32'h40);
    lat <= 4'h0;
    op(16'h0086, 8'h24, 32'h21, 2'b01);
    chk({24'h0, mem.m[8'h45]}, {24'h0, pb(8'h45) & 8'hc0});
    chk({24'h0, mem.m[8'h44]}, {24'h0, pb(8'h44)});
    op(16'h0506, 8'h34, 32'h0, 2'b10);
    $display("t_load done");
  endtask

  // Halfword branch keeps latches; halfword load clears byte X
  task automatic t_half;
    bus(1'b1, OFF_EXT45, 32'h10);
    bus(1'b1, 8'h3c, 32'h3fffff);
    op(16'h1001, OFF_IAR, {16'h0, pb(8'h20), pb(8'h21)}, 2'b10);
    chk({10'h0, branch_addr}, {16'h0, pb(8'h20), pb(8'h21)});
    sticky(32'h10);
    op(16'h077f, 8'h3c, {16'h0, pb(8'h8e), pb(8'h8f)}, 2'b01);
    $display("t_half done");
  endtask

  // Byte insert: even, odd and zero characters, odd register only
  task automatic t_ins;
    bus(1'b1, OFF_EXT44, 32'h20);
    bus(1'b1, 8'h2c, 32'h2aaaaa);
    op(16'h0a7f, 8'h2c, {10'h0, 6'h2a, pb(8'h9f), 8'haa}, 2'b01);
    op(16'h0a00, 8'h2c, {10'h0, 6'h2a, pb(8'h20), 8'haa}, 2'b00);
    op(16'h0f26, 8'h3c, {16'h0, pb(8'h8e), 8'h00}, 2'b11);
    bus(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h0);
    $display("t_ins done");
  endtask

  // Autoincrement: same register, other register, then base zero refused
  task automatic t_autoinc;
    lat <= 4'h2;
    bus(1'b1, 8'h34, 32'h30);
    op(16'h5510, 8'h34, {24'h0, pb(8'h30)}, 2'b11);
    op(16'h1210, 8'h24, 32'h22, 2'b11);
    op(16'h0210, 8'h2c, {10'h0, 6'h2a, pb(8'h21), 8'haa}, 2'b11);
    sticky(32'h08);
    op(16'hc000, 8'h24, 32'h22, 2'b11);
    sticky(32'h08);
    $display("t_autoinc done");
  endtask

  // Immediate address into a register and into the instruction address
  task automatic t_imm;
    bus(1'b1, OFF_AEXT, 32'h1234);
    op(16'hbe0f, 8'h38, 32'h0f1234, 2'b11);
    bus(1'b1, OFF_AEXT, 32'habcd);
    op(16'hb803, OFF_IAR, 32'h03abcd, 2'b11);
    chk({10'h0, branch_addr}, 32'h03abcd);
    sticky(32'h10);
    $display("t_imm done");
  endtask

  // Shift-copy byte 1 of register 1 into byte 0 of register 3
  task automatic t_shift;
    bus(1'b1, 8'h2c, 32'h0);
    bus(1'b1, 8'h24, 32'h81);
    op(16'h1278, 8'h2c, 32'h4000, 2'b01);
    bus(1'b1, 8'h24, 32'h02);
    op(16'h1278, 8'h2c, 32'h0100, 2'b00);
    bus(1'b1, 8'h24, 32'h01);
    op(16'h1278, 8'h2c, 32'h0000, 2'b11);
    $display("t_shift done");
  endtask

  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cut a hang short far beyond the expected run
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    report_and_stop;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    lat = 4'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_load;
    t_half;
    t_ins;
    t_autoinc;
    t_imm;
    t_shift;
    report_and_stop;
  end
endmodule
`default_nettype wire
